// >>> icrw_decoder.sv
// Bistable decoder with inactivity watchdog for one isolation channel
`timescale 1ns/100ps
`default_nettype none
module icrw_decoder
	import icrw_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic rx_enable_i,
	input wire icrw_pulse_s pulse_i,
	output logic level_o,
	output logic oe_o,
	output logic live_o
);

	icrw_dec_state_e state_q;
	logic level_q;
	logic [CNT_W-1:0] wd_q;
	logic any_pulse;

	assign any_pulse = pulse_i.set | pulse_i.clr;

	// ----------------------------------------
	// Output state
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !rx_enable_i) begin
			state_q <= DEC_HIZ;
			level_q <= 1'b0;
		end else begin
			case (state_q)
				DEC_HIZ: begin
					state_q <= DEC_LOW;
					level_q <= 1'b0;
				end
				DEC_LOW: begin
					if (any_pulse) begin
						state_q <= DEC_LIVE;
						level_q <= pulse_i.set;
					end
				end
				DEC_LIVE: begin
					if (pulse_i.set) begin
						level_q <= 1'b1;
					end else if (pulse_i.clr) begin
						level_q <= 1'b0;
					end else if (wd_q == WATCHDOG_CYC) begin
						state_q <= DEC_LOW;
						level_q <= 1'b0;
					end
				end
				default: begin
					state_q <= DEC_HIZ;
					level_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Watchdog, restarted by data and refresh alike
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !rx_enable_i || any_pulse || state_q != DEC_LIVE) begin
			wd_q <= CNT_RST;
		end else if (wd_q != WATCHDOG_CYC) begin
			wd_q <= wd_q + 8'h01;
		end
	end

	assign level_o = level_q;
	assign oe_o = (state_q != DEC_HIZ);
	assign live_o = (state_q == DEC_LIVE);

endmodule
`default_nettype wire

// >>> icrw_encoder.sv
// Edge and refresh pulse encoder for one isolation channel
`timescale 1ns/100ps
`default_nettype none
module icrw_encoder
	import icrw_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic tx_enable_i,
	input wire logic level_i,
	output icrw_pulse_s pulse_o
);

	logic prev_q;
	logic armed_q;
	logic [CNT_W-1:0] idle_q;
	icrw_pulse_s pulse_q;

	// ----------------------------------------
	// Pulse generation
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !tx_enable_i) begin
			prev_q <= 1'b0;
			armed_q <= 1'b0;
			idle_q <= CNT_RST;
			pulse_q <= '0;
		end else begin
			prev_q <= level_i;
			armed_q <= 1'b1;
			if (!armed_q || level_i != prev_q) begin
				// First sample after power-up sends the present level
				pulse_q.set <= level_i;
				pulse_q.clr <= ~level_i;
				idle_q <= CNT_RST;
			end else if (idle_q == REFRESH_CYC) begin
				pulse_q.set <= level_i;
				pulse_q.clr <= ~level_i;
				idle_q <= CNT_RST;
			end else begin
				// One cycle is the shortest pulse this clock can make
				pulse_q <= '0;
				idle_q <= idle_q + 8'h01;
			end
		end
	end

	assign pulse_o = pulse_q;

endmodule
`default_nettype wire

// >>> icrw_pkg.sv
// Shared constants and types for the isolated channel refresh and watchdog block
package icrw_pkg;

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int PULSE_NS = 1;
	localparam int REFRESH_IDLE_NS = 1000;
	localparam int WATCHDOG_NS = 5000;

	// ----------------------------------------
	// Cycle counts, refresh and watchdog rounded up, pulse rounded down, none below one
	// ----------------------------------------
	localparam int CNT_W = 8;
	localparam int PULSE_CYC_INT = (PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (PULSE_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(PULSE_CYC_INT);
	localparam logic [CNT_W-1:0] REFRESH_CYC =
		CNT_W'((REFRESH_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WATCHDOG_CYC =
		CNT_W'((WATCHDOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Channel layout and reset values
	// ----------------------------------------
	localparam int NUM_CHAN = 4;
	localparam logic [NUM_CHAN-1:0] CHAN_REVERSE_DEFAULT = 4'h8;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam int SYNC_W = NUM_CHAN + 3;
	localparam int SYNC_PRI = NUM_CHAN;
	localparam int SYNC_ISO = NUM_CHAN + 1;
	localparam int SYNC_REG = NUM_CHAN + 2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic set;
		logic clr;
	} icrw_pulse_s;

	typedef enum logic [2:0] {
		DEC_HIZ = 3'h1,
		DEC_LOW = 3'h2,
		DEC_LIVE = 3'h4
	} icrw_dec_state_e;

	typedef enum logic [2:0] {
		OSC_OFF = 3'h1,
		OSC_FREE = 3'h2,
		OSC_REG = 3'h4
	} icrw_osc_state_e;

endpackage

// >>> icrw_side_model.sv
// Side logic that drives the channel inputs and reads the outputs
`timescale 1ns/100ps
`default_nettype none
module icrw_side_model (
	input wire logic core_clk_i,
	input wire logic [3:0] want_i,
	input wire logic [3:0] chan_out_i,
	input wire logic [3:0] valid_i,
	output logic [3:0] chan_in_o,
	output logic [3:0] trusted_o
);
	// ----------------------------------------
	// Pins and readback
	// ----------------------------------------
	initial chan_in_o = 4'h0;
	always @(posedge core_clk_i) begin
		chan_in_o <= #1 want_i;
	end
	// Data ignored until the channel is live, supply may still be settling
	assign trusted_o = chan_out_i & valid_i;
endmodule
`default_nettype wire

// >>> icrw_top.sv
// Four-channel isolated link with refresh, watchdog and lockout gating
// ----------------------------------------
// Contract
// - Each input edge sends one one-cycle pulse, set for rising and clear for falling.
// - The decoder is bistable: set drives high, clear drives low, level holds between.
// - After more than one microsecond without an edge, refresh pulses of the level repeat.
// - With no pulse for more than five microseconds the output is forced low.
// - Below lockout a side keeps its oscillator, channel drivers and refresh idle.
// - Below lockout the channel outputs of that side are high impedance.
// - On primary power-up primary outputs start low until the first pulse arrives.
// - Once primary power is good, primary inputs are sampled and sent at once.
// - The oscillator runs free at full power until regulation is seen, then follows it.
// - On isolated power-up secondary outputs start low and follow the input within 1 us; the code can take up to 44 cycles, 1.1 us.
// - Secondary inputs are sent once the secondary is active, valid two cycles later.
// - On primary lockout the converter and primary coupling stop sending pulses.
// - After primary shutdown secondary outputs hold, then go high impedance or low.
// ----------------------------------------
`timescale 1ns/100ps
`default_nettype none
module icrw_top
	import icrw_pkg::*;
#(
	parameter logic [NUM_CHAN-1:0] CHAN_REVERSE = CHAN_REVERSE_DEFAULT
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic primary_supply_ok_i,
	input wire logic isolated_supply_ok_i,
	input wire logic regulation_ctrl_i,
	input wire logic [NUM_CHAN-1:0] chan_in_i,
	output logic [NUM_CHAN-1:0] chan_out_o,
	output logic [NUM_CHAN-1:0] chan_out_oe_o,
	output logic [NUM_CHAN-1:0] chan_out_valid_o,
	output icrw_pulse_s [NUM_CHAN-1:0] barrier_o,
	output logic primary_active_o,
	output logic isolated_active_o,
	output logic osc_enable_o,
	output logic osc_drive_o,
	output logic osc_regulated_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;

	assign pins = {regulation_ctrl_i, isolated_supply_ok_i, primary_supply_ok_i, chan_in_i};

	genvar s;
	generate
		for (s = 0; s < SYNC_W; s++) begin : g_sync
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					sync1_q[s] <= 1'b0;
					sync2_q[s] <= 1'b0;
				end else begin
					sync1_q[s] <= pins[s];
					sync2_q[s] <= sync1_q[s];
				end
			end
		end
	endgenerate

	logic pri_ok;
	logic iso_ok;
	logic reg_ctrl;

	assign pri_ok = sync2_q[SYNC_PRI];
	// Secondary lockout kept apart from primary so its outputs can hold on primary loss
	assign iso_ok = sync2_q[SYNC_ISO];
	assign reg_ctrl = sync2_q[SYNC_REG];

	// ----------------------------------------
	// Power oscillator control
	// ----------------------------------------
	icrw_osc_state_e osc_q;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			osc_q <= OSC_OFF;
		end else begin
			case (osc_q)
				OSC_OFF: begin
					if (pri_ok) begin
						osc_q <= OSC_FREE;
					end
				end
				OSC_FREE: begin
					if (!pri_ok) begin
						osc_q <= OSC_OFF;
					end else if (iso_ok && reg_ctrl) begin
						osc_q <= OSC_REG;
					end
				end
				OSC_REG: begin
					if (!pri_ok) begin
						osc_q <= OSC_OFF;
					end else if (!iso_ok) begin
						// Secondary lost: no regulation signal can come back
						osc_q <= OSC_FREE;
					end
				end
				default: begin
					osc_q <= OSC_OFF;
				end
			endcase
		end
	end

	logic osc_drive_q;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			osc_drive_q <= 1'b0;
		end else begin
			case (osc_q)
				OSC_FREE: osc_drive_q <= pri_ok;
				OSC_REG: osc_drive_q <= pri_ok & reg_ctrl;
				default: osc_drive_q <= 1'b0;
			endcase
		end
	end

	assign osc_enable_o = (osc_q != OSC_OFF);
	assign osc_drive_o = osc_drive_q;
	assign osc_regulated_o = (osc_q == OSC_REG);
	assign primary_active_o = pri_ok;
	assign isolated_active_o = iso_ok;

	// ----------------------------------------
	// Channel slices
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < NUM_CHAN; c++) begin : g_chan
			logic tx_en;
			logic rx_en;
			icrw_pulse_s pulse;

			// Each slice sends from its own input side and decodes on its output side
			// Reverse pulses need the primary half of the coupler alive
			assign tx_en = CHAN_REVERSE[c] ? (iso_ok & pri_ok) : pri_ok;
			assign rx_en = CHAN_REVERSE[c] ? pri_ok : iso_ok;

			icrw_encoder u_enc (
				.core_clk_i(core_clk_i),
				.sys_rst_i(sys_rst_i),
				.tx_enable_i(tx_en),
				.level_i(sync2_q[c]),
				.pulse_o(pulse)
			);

			icrw_decoder u_dec (
				.core_clk_i(core_clk_i),
				.sys_rst_i(sys_rst_i),
				.rx_enable_i(rx_en),
				.pulse_i(pulse),
				.level_o(chan_out_o[c]),
				.oe_o(chan_out_oe_o[c]),
				.live_o(chan_out_valid_o[c])
			);

			assign barrier_o[c] = pulse;
		end
	endgenerate

endmodule
`default_nettype wire

// >>> icrw_top_monitor.sv
// Port checker for the isolated channel link
`timescale 1ns/100ps
`default_nettype none
module icrw_top_monitor
	import icrw_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [NUM_CHAN-1:0] chan_out_o,
	input wire logic [NUM_CHAN-1:0] chan_out_oe_o,
	input wire logic [NUM_CHAN-1:0] chan_out_valid_o,
	input wire icrw_pulse_s [NUM_CHAN-1:0] barrier_o,
	input wire logic primary_active_o,
	input wire logic isolated_active_o,
	input wire logic osc_enable_o,
	input wire logic osc_drive_o,
	input wire logic osc_regulated_o
);
	// ----------------------------------------
	// Pulse gap counters
	// ----------------------------------------
	logic [7:0] gap_q;
	logic [7:0] quiet_q;
	wire logic p0 = barrier_o[0].set | barrier_o[0].clr;
	wire logic p3 = barrier_o[3].set | barrier_o[3].clr;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || p0 || !primary_active_o) begin
			gap_q <= 8'h00;
		end else begin
			gap_q <= gap_q + 8'h01;
		end
	end
	// Saturates so a dead sender never wraps back to a small count
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || p3 || !primary_active_o || !chan_out_valid_o[3]) begin
			quiet_q <= 8'h00;
		end else if (quiet_q != 8'hFF) begin
			quiet_q <= quiet_q + 8'h01;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_set_live;
		(barrier_o[0].set && chan_out_oe_o[0]) ##1 chan_out_oe_o[0];
	endsequence
	sequence s_clr_live;
		(barrier_o[0].clr && chan_out_oe_o[0]) ##1 chan_out_oe_o[0];
	endsequence
	a_pulse_single: assert property (barrier_o[0].set |=> !barrier_o[0].set)
		else $error("set pulse wider than one cycle");
	a_set_high: assert property (s_set_live |-> chan_out_o[0])
		else $error("set pulse did not drive output high");
	a_clr_low: assert property (s_clr_live |-> !chan_out_o[0])
		else $error("clear pulse did not drive output low");
	a_hold_level: assert property (chan_out_valid_o[0] && $past(chan_out_valid_o[0])
		&& !$past(p0) |-> $stable(chan_out_o[0]))
		else $error("output moved without a pulse");
	a_refresh_gap: assert property (gap_q < 8'h2A)
		else $error("no pulse within the refresh period");
	a_watchdog_late: assert property (quiet_q < 8'hD2)
		else $error("output still live after pulses stopped");
	a_watchdog_early: assert property ($fell(chan_out_valid_o[3])
		&& primary_active_o && $past(primary_active_o) |-> quiet_q >= 8'hC0)
		else $error("watchdog fired too early");
	a_lockout_idle: assert property (!primary_active_o [*3] |->
		!osc_enable_o && barrier_o == '0)
		else $error("activity below primary lockout");
	a_hiz_below: assert property (!isolated_active_o [*2] |-> !chan_out_oe_o[0])
		else $error("output driven below lockout");
	a_start_low: assert property ($rose(chan_out_oe_o[0]) |-> !chan_out_o[0])
		else $error("secondary output did not start low");
	a_pri_start_low: assert property ($rose(chan_out_oe_o[3]) |-> !chan_out_o[3])
		else $error("primary output did not start low");
	a_free_run: assert property ((osc_enable_o && !osc_regulated_o) [*2] |-> osc_drive_o)
		else $error("oscillator not at full drive");
endmodule
bind icrw_top icrw_top_monitor mon_u (.core_clk_i, .sys_rst_i, .chan_out_o, .chan_out_oe_o,
	.chan_out_valid_o, .barrier_o, .primary_active_o, .isolated_active_o, .osc_enable_o,
	.osc_drive_o, .osc_regulated_o);
`default_nettype wire

// >>> icrw_top_tb.sv
// Self-checking bench for the isolated channel link
`timescale 1ns/100ps
`default_nettype none
module icrw_top_tb import icrw_pkg::*;;
	// ----------------------------------------
	// Stimulus and checks
	// ----------------------------------------
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic pri_ok = 1'b0;
	logic iso_ok = 1'b0;
	logic reg_ctrl = 1'b0;
	logic [3:0] want = 4'h0;
	logic [3:0] chan_in, chan_out, oe, valid, trusted;
	icrw_pulse_s [NUM_CHAN-1:0] barrier;
	logic pri_act, iso_act, osc_en, osc_drv, osc_reg;
	int bad_count = 0;
	int compares = 0;
	always #12.5 core_clk_i = ~core_clk_i;
	icrw_top dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.primary_supply_ok_i(pri_ok), .isolated_supply_ok_i(iso_ok),
		.regulation_ctrl_i(reg_ctrl), .chan_in_i(chan_in), .chan_out_o(chan_out),
		.chan_out_oe_o(oe), .chan_out_valid_o(valid), .barrier_o(barrier),
		.primary_active_o(pri_act), .isolated_active_o(iso_act), .osc_enable_o(osc_en),
		.osc_drive_o(osc_drv), .osc_regulated_o(osc_reg));
	icrw_side_model side_u (.core_clk_i(core_clk_i), .want_i(want), .chan_out_i(chan_out),
		.valid_i(valid), .chan_in_o(chan_in), .trusted_o(trusted));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			step(1);
			n++;
		end while (barrier[0] === 2'b00 && n < 60);
	endtask
	task automatic t_power_up;
		int n;
		check({oe, valid}, 8'h00);
		pri_ok = 1'b1;
		step(6);
		check({pri_act, iso_act, osc_en, osc_drv, osc_reg}, 8'h16);
		check({oe, chan_out}, 8'h80);
		wait_pulse(n);
		check(8'(n < 60), 8'h01);
	endtask
	task automatic t_iso_up;
		want = 4'h9;
		iso_ok = 1'b1;
		step(46);
		check({valid, chan_out}, 8'hF9);
		check(trusted, 4'h9);
		reg_ctrl = 1'b1;
		step(5);
		check({osc_reg, osc_drv}, 2'b11);
		reg_ctrl = 1'b0;
		step(5);
		check({osc_reg, osc_drv}, 2'b10);
	endtask
	task automatic t_edges;
		int n, s, c;
		wait_pulse(n);
		s = 0;
		c = 0;
		for (int i = 0; i < 14; i++) begin
			if (i < 4) want[0] = ~want[0];
			step(1);
			s += barrier[0].set;
			c += barrier[0].clr;
		end
		check({s[3:0], c[3:0]}, 8'h22);
		check(chan_out[0], 1'b1);
	endtask
	task automatic t_refresh;
		int n;
		wait_pulse(n);
		wait_pulse(n);
		check(8'(n), REFRESH_CYC + 8'h01);
	endtask
	task automatic t_watchdog;
		iso_ok = 1'b0;
		step(100);
		check({oe, valid}, 8'h88);
		step(130);
		check({oe, valid}, 8'h80);
		check(chan_out, 4'h0);
	endtask
	task automatic t_pri_down;
		int n;
		iso_ok = 1'b1;
		step(50);
		pri_ok = 1'b0;
		step(5);
		check({oe, osc_en, pri_act, iso_act}, 8'h39);
		check({valid, chan_out}, 8'h71);
		wait_pulse(n);
		check(8'(n), 8'h3C);
		step(200);
		check({oe, valid}, 8'h70);
		check(chan_out, 4'h0);
		iso_ok = 1'b0;
		step(5);
		check(oe, 4'h0);
	endtask
	task automatic give_verdict;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		step(20);
		sys_rst_i = 1'b0;
		step(2);
		t_power_up;
		t_iso_up;
		t_edges;
		t_refresh;
		t_watchdog;
		t_pri_down;
		give_verdict;
	end
	// Whole run is near 20 us, so this only trips on a hang
	initial begin
		#100000;
		bad_count++;
		give_verdict;
	end
endmodule
`default_nettype wire
